/* File: logic/pkmc_bank.sv */
// one operand memory bank held in flip-flops
`timescale 1ns/1ps
module pkmc_bank #(
  parameter int unsigned DEPTH  = 32,
  parameter int unsigned IDX_W  = 5,
  parameter int unsigned WORD_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              clr_en,
  input  wire logic [IDX_W-1:0]  clr_idx,
  input  wire logic              wr_en,
  input  wire logic [IDX_W-1:0]  wr_idx,
  input  wire logic [WORD_W-1:0] wr_data,
  input  wire logic [IDX_W-1:0]  rd_idx,
  output logic      [WORD_W-1:0] rd_data
);

  logic [WORD_W-1:0] mem_q [DEPTH];

  // clear has priority over a host write
  always_ff @(posedge aclk) begin
    if (clr_en) begin
      mem_q[clr_idx] <= '0;
    end else if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem_q[rd_idx];

endmodule : pkmc_bank

/* File: logic/pkmc_pkg.sv */
// package: constants and types of the public-key mode-control block
package pkmc_pkg;

  // ****************************************
  // bus layout
  // ****************************************
  localparam int unsigned AXI_AW     = 12;
  localparam int unsigned AXI_DW     = 32;
  localparam logic [11:0] OFF_CTRL   = 12'h000;    // pk_mode_control
  localparam logic [11:0] OFF_STAT   = 12'h004;    // pk_status_reg
  localparam logic [11:0] OFF_SCALAR = 12'h008;    // scalar_input_reg
  localparam logic [4:0]  BANK_BASE  = 5'h02;      // addr[11:7] of bank A; B and N follow
  localparam logic [4:0]  NUM_BANKS  = 5'h03;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // operand memories and sequencer
  // ****************************************
  localparam int unsigned MEM_DEPTH  = 32;
  localparam int unsigned MEM_IDX_W  = 5;
  localparam int unsigned WORD_W     = 16;
  localparam logic [4:0]  CLR_LAST   = 5'h1F;      // last index walked by clear-all

  // ****************************************
  // control and status fields
  // ****************************************
  localparam int unsigned BIT_POLY   = 7;
  localparam int unsigned BIT_PROJ   = 8;
  localparam int unsigned BIT_ALTC   = 9;
  localparam int unsigned BIT_SRST   = 10;
  localparam int unsigned BIT_IRQ_EN = 11;
  localparam int unsigned BIT_GO     = 12;
  localparam int unsigned BIT_ECC    = 13;
  localparam logic [15:0] CTRL_RW_MASK = 16'h2B80; // static bits 7,8,9,11,13
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam int unsigned STAT_SRDY  = 11;
  localparam int unsigned STAT_IRQ   = 12;
  localparam int unsigned STAT_DONE  = 13;
  localparam logic [31:0] SCALAR_RESET = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PKMC_IDLE  = 2'b00,
    PKMC_RUN   = 2'b01,
    PKMC_CLEAR = 2'b10
  } pkmc_state_e;

  typedef struct packed {
    logic ecc_routine_sel;
    logic interrupt_enable_bit;
    logic alt_modulus_const_sel;
    logic projective_output_sel;
    logic polynomial_basis_sel;
  } pkmc_mode_s;

endpackage : pkmc_pkg

/* File: logic/pkmc_top.sv */
// public-key engine mode control: register bank, sequencer control, operand memories
//
// Contract
// - bit 7 set selects polynomial-basis arithmetic, clear selects integer arithmetic.
// - bit 8 set: only X, Y, Z out, converted from Montgomery form.
// - bit 8 clear: also Z squared, Z cubed, kept in Montgomery form.
// - bit 9 selects R squared mod N (0) or Rp*Rn mod P (1).
// - writing 1 to bit 10 resets registers, program counter, execution, interrupt.
// - soft reset runs clear-all over the A, B and N memories.
// - bit 11 gates the interrupt output; clear holds it at 0.
// - status interrupt flag sets on events regardless of the enable.
// - bit 12 runs from program counter until a jump to address 0.
// - host memory reads and writes are ignored while executing.
// - bit 13 selects elliptic-curve routines (1) or RSA routines (0).
// - run and soft reset bits self-clear one cycle after the write.
// - unused control bits always read back 0.
// - jump to 0 after run sets completion bit, then interrupt if enabled.
`timescale 1ns/1ps
module pkmc_top
  import pkmc_pkg::*;
#(
  parameter int unsigned PC_W = 8
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite slave
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [pkmc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [pkmc_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic      [1:0]                 s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [pkmc_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic      [pkmc_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  // sequencer and datapath side
  input  wire logic                       seq_step,
  input  wire logic                       seq_jump,
  input  wire logic [PC_W-1:0]            seq_jump_addr,
  input  wire logic                       seq_scalar_req,
  output pkmc_pkg::pkmc_mode_s            mode,
  output logic      [PC_W-1:0]            seq_pc,
  output logic                            seq_running,
  output logic                            seq_go,
  output logic                            eng_soft_reset,
  output logic                            clear_all_busy,
  output logic                            zpow_results_en,
  output logic                            mont_convert_out,
  output logic      [31:0]                scalar_word,
  output logic                            scalar_load,
  output logic                            irq
);

  // ****************************************
  // write channel capture
  // ****************************************
  logic                aw_got_q;
  logic [AXI_AW-1:0]   awaddr_q;
  logic                w_got_q;
  logic [AXI_DW-1:0]   wdata_q;
  logic [3:0]          wstrb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;

  wire                 aw_hs   = s_axi_awvalid & s_axi_awready;
  wire                 w_hs    = s_axi_wvalid & s_axi_wready;
  wire                 aw_have = aw_got_q | s_axi_awvalid;
  wire                 w_have  = w_got_q | s_axi_wvalid;
  wire                 wr_fire = aw_have & w_have & ~bvalid_q;
  wire [AXI_AW-1:0]    wa      = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [AXI_DW-1:0]    wd      = w_got_q ? wdata_q : s_axi_wdata;
  wire [3:0]           ws      = w_got_q ? wstrb_q : s_axi_wstrb;

  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ****************************************
  // write decode
  // ****************************************
  pkmc_state_e         state_q;
  wire                 idle    = (state_q == PKMC_IDLE);
  wire [4:0]           wa_bank = wa[11:7] - BANK_BASE;
  wire                 wa_mem  = (wa[11:7] >= BANK_BASE) & (wa_bank < NUM_BANKS);
  wire                 wr_ctrl = wr_fire & ({wa[11:2], 2'b00} == OFF_CTRL);
  wire                 wr_stat = wr_fire & ({wa[11:2], 2'b00} == OFF_STAT);
  wire                 wr_scal = wr_fire & ({wa[11:2], 2'b00} == OFF_SCALAR);
  wire                 wr_mem  = wr_fire & wa_mem & idle & (ws[1:0] == 2'b11);
  wire                 wr_map  = wr_ctrl | wr_stat | wr_scal | (wr_fire & wa_mem);

  // write response after both halves are taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (aw_hs) awaddr_q <= s_axi_awaddr;
      if (w_hs) wdata_q <= s_axi_wdata;
      if (w_hs) wstrb_q <= s_axi_wstrb;
      aw_got_q <= wr_fire ? 1'b0 : (aw_got_q | aw_hs);
      w_got_q  <= wr_fire ? 1'b0 : (w_got_q | w_hs);
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // control register
  // ****************************************
  logic [15:0]         ctrl_q;
  logic                srst_q;
  logic                go_q;
  wire                 eng_rst  = ~aresetn | srst_q;
  wire [15:0]          ctrl_new = {ws[1] ? wd[15:8] : ctrl_q[15:8],
                                   ws[0] ? wd[7:0]  : ctrl_q[7:0]};
  wire                 srst_set = wr_ctrl & ws[1] & wd[BIT_SRST];
  wire                 go_set   = wr_ctrl & ws[1] & wd[BIT_GO];

  // dynamic bits stand for exactly one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= srst_set;
    end
  end

  // static bits and run pulse are cleared by soft reset too
  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      ctrl_q <= CTRL_RESET;
      go_q   <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_new & CTRL_RW_MASK;
      go_q <= go_set & ~srst_set;
    end
  end

  // mode outputs to the engine
  assign mode.polynomial_basis_sel  = ctrl_q[BIT_POLY];
  assign mode.projective_output_sel = ctrl_q[BIT_PROJ];
  assign mode.alt_modulus_const_sel = ctrl_q[BIT_ALTC];
  assign mode.interrupt_enable_bit  = ctrl_q[BIT_IRQ_EN];
  assign mode.ecc_routine_sel       = ctrl_q[BIT_ECC];
  assign mont_convert_out = ctrl_q[BIT_PROJ];
  assign zpow_results_en  = ~ctrl_q[BIT_PROJ];
  assign eng_soft_reset   = srst_q;
  assign seq_go           = go_q;

  // ****************************************
  // sequencer control
  // ****************************************
  logic [PC_W-1:0]     pc_q;
  logic [MEM_IDX_W-1:0] clr_idx_q;
  wire                 jump0   = seq_step & seq_jump & (seq_jump_addr == '0);
  wire                 done_ev = (state_q == PKMC_RUN) & jump0;

  // run from the current counter until a jump to address 0
  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      state_q   <= PKMC_CLEAR;
      pc_q      <= '0;
      clr_idx_q <= '0;
    end else begin
      case (state_q)
        PKMC_CLEAR: begin
          clr_idx_q <= clr_idx_q + 1'b1;
          if (clr_idx_q == CLR_LAST) state_q <= PKMC_IDLE;
        end
        PKMC_IDLE: begin
          if (go_q) state_q <= PKMC_RUN;
        end
        PKMC_RUN: begin
          if (seq_step) begin
            pc_q <= seq_jump ? seq_jump_addr : pc_q + 1'b1;
          end
          if (jump0) state_q <= PKMC_IDLE;
        end
        default: begin
          state_q <= PKMC_IDLE;
        end
      endcase
    end
  end

  assign seq_pc         = pc_q;
  assign seq_running    = (state_q == PKMC_RUN);
  assign clear_all_busy = (state_q == PKMC_CLEAR);

  // ****************************************
  // status and scalar input
  // ****************************************
  logic                done_q;
  logic                srdy_q;
  logic [31:0]         scalar_q;
  logic                scalar_load_q;
  wire                 irq_flag = done_q | srdy_q;

  // events win over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      done_q        <= 1'b0;
      srdy_q        <= 1'b0;
      scalar_q      <= SCALAR_RESET;
      scalar_load_q <= 1'b0;
    end else begin
      done_q        <= done_ev | (done_q & ~wr_stat);
      srdy_q        <= seq_scalar_req | (srdy_q & ~wr_stat & ~wr_scal);
      scalar_load_q <= wr_scal;
      for (int b = 0; b < 4; b++) begin
        if (wr_scal & ws[b]) scalar_q[8*b +: 8] <= wd[8*b +: 8];
      end
    end
  end

  assign scalar_word = scalar_q;
  assign scalar_load = scalar_load_q;
  assign irq         = irq_flag & ctrl_q[BIT_IRQ_EN];

  // ****************************************
  // operand memories A, B, N
  // ****************************************
  wire [4:0]           ra_bank = s_axi_araddr[11:7] - BANK_BASE;
  wire                 ra_mem  = (s_axi_araddr[11:7] >= BANK_BASE) & (ra_bank < NUM_BANKS);
  logic [WORD_W-1:0]   bank_rd [3];

  for (genvar g = 0; g < 3; g++) begin : g_bank
    pkmc_bank #(
      .DEPTH  (MEM_DEPTH),
      .IDX_W  (MEM_IDX_W),
      .WORD_W (WORD_W)
    ) u_bank (
      .aclk    (aclk),
      .clr_en  (state_q == PKMC_CLEAR),
      .clr_idx (clr_idx_q),
      .wr_en   (wr_mem & (wa_bank[1:0] == 2'(g))),
      .wr_idx  (wa[6:2]),
      .wr_data (wd[15:0]),
      .rd_idx  (s_axi_araddr[6:2]),
      .rd_data (bank_rd[g])
    );
  end

  // ****************************************
  // read channel
  // ****************************************
  logic                rvalid_q;
  logic [AXI_DW-1:0]   rdata_q;
  logic [1:0]          rresp_q;
  wire [11:0]          ra      = {s_axi_araddr[11:2], 2'b00};
  wire                 ar_hs   = s_axi_arvalid & s_axi_arready;
  wire [15:0]          ctrl_rd = ctrl_q | (16'(srst_q) << BIT_SRST) | (16'(go_q) << BIT_GO);
  wire [15:0]          stat_rd = (16'(srdy_q) << STAT_SRDY) | (16'(irq_flag) << STAT_IRQ)
                                 | (16'(done_q) << STAT_DONE);
  wire [15:0]          mem_rd  = idle ? bank_rd[ra_bank[1:0]] : 16'h0000;
  wire                 ra_map  = (ra == OFF_CTRL) | (ra == OFF_STAT) | (ra == OFF_SCALAR) | ra_mem;
  wire [AXI_DW-1:0]    rd_mux  = (ra == OFF_CTRL)   ? {16'h0000, ctrl_rd} :
                                 (ra == OFF_STAT)   ? {16'h0000, stat_rd} :
                                 (ra == OFF_SCALAR) ? scalar_q :
                                 ra_mem             ? {16'h0000, mem_rd} : 32'h0000_0000;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // read data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= ra_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : pkmc_top

/* File: testbench/pkmc_top_assertions.sv */
// checker: concurrent properties on the mode-control block ports
`timescale 1ns/1ps
module pkmc_top_assertions
  import pkmc_pkg::*;
#(
  parameter int unsigned PC_W = 8
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            seq_step,
  input wire logic            seq_jump,
  input wire logic [PC_W-1:0] seq_jump_addr,
  input pkmc_pkg::pkmc_mode_s mode,
  input wire logic            seq_running,
  input wire logic            seq_go,
  input wire logic            eng_soft_reset,
  input wire logic            clear_all_busy,
  input wire logic            zpow_results_en,
  input wire logic            mont_convert_out,
  input wire logic            irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // properties
  // ****************************************
  // a step that jumps back to address zero
  wire jump0 = seq_running && seq_step && seq_jump && (seq_jump_addr == '0);
  property p_go_pulse; $rose(seq_go) |=> $fell(seq_go); endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("run pulse too long");
  property p_srst_pulse; eng_soft_reset |=> !eng_soft_reset; endproperty
  a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset pulse too long");
  property p_srst_clr; eng_soft_reset |=> mode == '0 && !seq_running && !irq && clear_all_busy; endproperty
  a_srst_clr: assert property (p_srst_clr) else $error("soft reset left state behind");
  property p_go_run; seq_go && !seq_running && !clear_all_busy && !eng_soft_reset |=> seq_running; endproperty
  a_go_run: assert property (p_go_run) else $error("run did not start");
  property p_run_hold; seq_running && !seq_step && !eng_soft_reset |=> seq_running; endproperty
  a_run_hold: assert property (p_run_hold) else $error("run stopped without a jump");
  property p_stop; jump0 |=> !seq_running; endproperty
  a_stop: assert property (p_stop) else $error("run continued after jump to zero");
  property p_done_irq; jump0 && mode.interrupt_enable_bit |=> irq; endproperty
  a_done_irq: assert property (p_done_irq) else $error("no interrupt on completion");
  property p_irq_gate; !mode.interrupt_enable_bit |-> !irq; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt out while disabled");
  property p_fmt; mont_convert_out == mode.projective_output_sel && zpow_results_en != mont_convert_out; endproperty
  a_fmt: assert property (p_fmt) else $error("output format controls disagree");
  // main scenarios reached
  c_go: cover property (seq_go);
  c_stop: cover property (jump0 ##1 irq);
  c_srst: cover property (eng_soft_reset);
endmodule : pkmc_top_assertions

/* File: testbench/tb_pk_engine_mode_control.sv */
// testbench: random and directed checks of the mode-control block
`timescale 1ns/1ps
module tb_pk_engine_mode_control;
  import pkmc_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, seq_step = 1'h0, seq_jump = 1'h0, seq_scalar_req = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        seq_running, seq_go, eng_soft_reset, clear_all_busy, zpow_results_en, mont_convert_out;
  logic        scalar_load, irq;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, scalar_word;
  logic [3:0]  s_axi_wstrb = '0;
  logic [7:0]  seq_jump_addr = '0, seq_pc;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  pkmc_mode_s  mode;
  int          miscompares = 0, checks_done = 0;
  int          loads_seen = 0;
  // 250 MHz clock
  always #2 aclk = ~aclk;
  // count scalar load pulses while they stand
  always @(negedge aclk) begin
    if (scalar_load === 1'h1) loads_seen++;
  end
  pkmc_top #(.PC_W(8)) pkmc_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .seq_step(seq_step),
    .seq_jump(seq_jump), .seq_jump_addr(seq_jump_addr), .seq_scalar_req(seq_scalar_req), .mode(mode),
    .seq_pc(seq_pc), .seq_running(seq_running), .seq_go(seq_go), .eng_soft_reset(eng_soft_reset),
    .clear_all_busy(clear_all_busy), .zpow_results_en(zpow_results_en), .mont_convert_out(mont_convert_out),
    .scalar_word(scalar_word), .scalar_load(scalar_load), .irq(irq)
  );
  // ****************************************
  // tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // bounded wait ran out
  task automatic stall();
    miscompares++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    end_of_test();
  endtask : stall
  // write one word, address and data offered together, response compared
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb;
    int   n;
    tb = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk(s_axi_bresp, er, "bresp");
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
      n++;
      if (n > 50) stall();
    end
  endtask : wr
  // read one word and compare data and response
  task automatic rdchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er, input string what);
    logic ta, tr;
    int   n;
    tr = 1'h0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk(s_axi_rdata, ed, what);
      if (tr) chk(s_axi_rresp, er, "rresp");
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
      n++;
      if (n > 50) stall();
    end
  endtask : rdchk
  // one finished instruction, optionally a jump
  task automatic step(input logic j, input logic [7:0] a);
    @(posedge aclk);
    seq_step <= 1'h1;
    seq_jump <= j;
    seq_jump_addr <= a;
    @(posedge aclk);
    seq_step <= 1'h0;
    seq_jump <= 1'h0;
    @(negedge aclk);
  endtask : step
  task automatic wait_clear();
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 64) stall();
    end while (clear_all_busy !== 1'h0);
  endtask : wait_clear
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [11:0] mem [3];
    mem = '{12'h100, 12'h1FC, 12'h27C};
    void'($urandom(93943));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    wait_clear();
    rdchk(OFF_CTRL, 32'h0, RESP_OKAY, "ctrl reset");
    // static bits, random with corners, run, soft reset and bits 6, 14, 15 kept clear, reserved bits 0-5 and 16-31 driven
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'hFFFF_2BBF : (i == 1) ? 32'h0 : ($urandom() & 32'hFFFF_2BBF);
      wr(OFF_CTRL, d, 4'hF, RESP_OKAY);
      rdchk(OFF_CTRL, d & 32'h0000_2B80, RESP_OKAY, "ctrl readback");
      @(negedge aclk);
      chk(mode, {d[13], d[11], d[9], d[8], d[7]}, "mode");
      chk(mont_convert_out, d[8], "convert out");
      chk(zpow_results_en, !d[8], "z powers");
    end
    $display("test static bits done");
    // run to completion with interrupts off then on; memory locked meanwhile
    for (int irq_en = 0; irq_en < 2; irq_en++) begin
      wr(12'h100, 32'h0000_A5C3, 4'hF, RESP_OKAY);
      wr(OFF_CTRL, {20'h0, irq_en[0], 11'h0} | 32'h0000_1000, 4'hF, RESP_OKAY);
      wr(12'h100, 32'h0000_1111, 4'hF, RESP_OKAY);
      rdchk(12'h100, 32'h0, RESP_OKAY, "memory while running");
      step(1'h0, 8'h00);
      chk(seq_pc, 32'h1, "pc after step");
      step(1'h1, 8'h40);
      chk(seq_running, 32'h1, "running after jump");
      chk(seq_pc, 32'h40, "pc after jump");
      step(1'h1, 8'h00);
      chk(seq_running, 32'h0, "stopped");
      chk(irq, irq_en, "completion irq");
      rdchk(OFF_STAT, 32'h0000_3000, RESP_OKAY, "status done");
      rdchk(12'h100, 32'h0000_A5C3, RESP_OKAY, "memory kept");
      // affine results: host loads the inverted powers back once stopped
      d = $urandom() & 32'h0000_FFFF;
      wr(12'h184, d, 4'hF, RESP_OKAY);
      rdchk(12'h184, d, RESP_OKAY, "inverse loaded back");
      wr(OFF_STAT, $urandom(), 4'hF, RESP_OKAY);
      rdchk(OFF_STAT, 32'h0, RESP_OKAY, "status cleared");
    end
    $display("test run done");
    // soft reset in mid-run after a scalar interrupt is raised and withdrawn
    foreach (mem[k]) wr(mem[k], $urandom() | 32'h1, 4'hF, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_3B80, 4'hF, RESP_OKAY);
    step(1'h0, 8'h00);
    @(posedge aclk);
    seq_scalar_req <= 1'h1;
    @(posedge aclk);
    seq_scalar_req <= 1'h0;
    @(negedge aclk);
    chk(irq, 32'h1, "scalar irq");
    // while running only scalar and status are touched
    d = $urandom();
    wr(OFF_SCALAR, d, 4'hF, RESP_OKAY);
    chk(loads_seen, 32'h1, "scalar load pulse");
    chk(scalar_word, d, "scalar word");
    rdchk(OFF_SCALAR, d, RESP_OKAY, "scalar readback");
    rdchk(OFF_STAT, 32'h0, RESP_OKAY, "status after scalar write");
    chk(irq, 32'h0, "irq withdrawn by scalar write");
    wr(OFF_CTRL, 32'h0000_2F80, 4'hF, RESP_OKAY);
    @(negedge aclk);
    chk({seq_running, irq, seq_pc, mode}, 32'h0, "soft reset state");
    chk(clear_all_busy, 32'h1, "clear-all started");
    chk(scalar_word, 32'h0, "scalar after soft reset");
    rdchk(OFF_CTRL, 32'h0, RESP_OKAY, "ctrl after soft reset");
    rdchk(OFF_STAT, 32'h0, RESP_OKAY, "status after soft reset");
    wait_clear();
    foreach (mem[k]) rdchk(mem[k], 32'h0, RESP_OKAY, "memory cleared");
    $display("test soft reset done");
    // unmapped places
    rdchk(12'h00C, 32'h0, RESP_SLVERR, "unmapped read");
    wr(12'hFFC, $urandom(), 4'hF, RESP_SLVERR);
    $display("test unmapped done");
    end_of_test();
  end
endmodule : tb_pk_engine_mode_control
bind pkmc_top pkmc_top_assertions #(.PC_W(PC_W)) pkmc_top_assertions_i (
  .aclk(aclk), .aresetn(aresetn), .seq_step(seq_step), .seq_jump(seq_jump), .seq_jump_addr(seq_jump_addr),
  .mode(mode), .seq_running(seq_running), .seq_go(seq_go), .eng_soft_reset(eng_soft_reset),
  .clear_all_busy(clear_all_busy), .zpow_results_en(zpow_results_en), .mont_convert_out(mont_convert_out), .irq(irq)
);
